// File: hdl/swcs_pkg.sv
package swcs_pkg;
   // Register byte offsets on the APB slave.
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_BPDUR = 8'h04;
   localparam logic [7:0] A_OPSMAX = 8'h08;
   localparam logic [7:0] A_ISUMTHR = 8'h0C;
   localparam logic [7:0] A_HOURTHR = 8'h10;
   localparam logic [7:0] A_TOPEN = 8'h14;
   localparam logic [7:0] A_TCLOSE = 8'h18;
   localparam logic [7:0] A_STATUS = 8'h1C;
   localparam logic [7:0] A_OPS = 8'h20;
   localparam logic [7:0] A_SUM1 = 8'h24;
   localparam logic [7:0] A_SUM2 = 8'h28;
   localparam logic [7:0] A_SUM3 = 8'h2C;
   localparam logic [7:0] A_CAP = 8'h30;
   localparam logic [7:0] A_CMD = 8'h34;
   localparam logic [7:0] A_CLR = 8'h38;
   localparam logic [7:0] A_NPTS = 8'h3C;
   localparam logic [7:0] A_CURVE = 8'h40;
   localparam logic [7:0] A_WEARLVL = 8'h68;
   // Control register field positions.
   localparam int CTRL_AUTH_LSB = 0;
   localparam int CTRL_MODE_LSB = 2;
   localparam int CTRL_OVR_BIT = 4;
   localparam int CTRL_OVRPOS_LSB = 5;
   // Values after reset.
   localparam logic [7:0] CTRL_RST = 8'h03;
   localparam logic [31:0] TMOVE_RST = 32'h0000_FFFF;
   localparam logic [31:0] LIMIT_RST = 32'hFFFF_FFFF;
   localparam logic [31:0] BPDUR_RST = 32'h0000_FFFF;
   localparam logic [3:0] NPTS_RST = 4'h2;
   localparam logic [6:0] WEARLVL_RST = 7'h50;
   // Wear scale: full capacity is 100 percent in 16.16 fixed point.
   localparam logic [6:0] CAP_FULL = 7'h64;
   localparam logic [31:0] WEAR_FULL = 32'h0064_0000;
   // Rolling hour, kept as four quarter-hour buckets.
   localparam longint HOUR_S = 3600;
   localparam longint CLK_HZ = 40_000_000;
   localparam int N_BKT = 4;
   localparam logic [39:0] BKT_CYC = 40'(HOUR_S * CLK_HZ / N_BKT);
   // Command sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONFIRM = 2'b01,
      ST_MOVE = 2'b10
   } swcs_state_t;
   // Switching authority settings.
   typedef enum logic [1:0] {
      AUTH_NONE = 2'b00,
      AUTH_LOCAL = 2'b01,
      AUTH_REMOTE = 2'b10,
      AUTH_BOTH = 2'b11
   } swcs_auth_t;
   // Interlock bypass modes.
   typedef enum logic [1:0] {
      BP_OFF = 2'b00,
      BP_SINGLE = 2'b01,
      BP_PERM = 2'b10,
      BP_TIMED = 2'b11
   } swcs_bpmode_t;
   // Switchgear position codes.
   typedef enum logic [1:0] {
      POS_INDET = 2'b00,
      POS_OFF = 2'b01,
      POS_ON = 2'b10,
      POS_DIST = 2'b11
   } swcs_pos_t;
endpackage

// File: hdl/swcs_supervisor.sv
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// Contract
// - Bypass modes: single, permanent, timed
// - Duration limits timed and single bypass
// - External signal also enables bypass
// - Override replaces position, flags it active
// - One command at a time, others ignored
// - Suppress command if already in position
// - One close pulse per key press
// - Count operations, alarm above maximum
// - Per-phase current sums with alarms
// - Consumed capacity percent, maintenance at full
// - Rolling hourly current sum alarm
// - Slow travel flag on supervision timeout
// - Wear curve of ten points drives alarm
// - Last used point counts as zero
// - Interpolate between neighbouring curve points
// - Above last point allowed count zero
// - Local keys offered per authority, direction
// - Local close needs explicit confirmation
// - Report position on feedback or timeout
// - Open wins; close on edge, open level; the open key acts on its edge, and while confirming only a trip wins
// - Authority: none, local, remote, both
module swcs_supervisor #(
   parameter int N_PTS = 10,
   parameter logic [39:0] BUCKET_CYCLES = swcs_pkg::BKT_CYC
) (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Panel keys.
   input wire logic i_key_open,
   input wire logic i_key_close,
   input wire logic i_key_yes,
   input wire logic i_key_no,
   output logic o_offer_open,
   output logic o_offer_close,
   output logic o_confirm_pending,
   // External commands, trip and interlocks.
   input wire logic i_ext_open,
   input wire logic i_ext_close,
   input wire logic i_prot_trip,
   input wire logic i_bypass_ext,
   input wire logic i_ilock_open_ok,
   input wire logic i_ilock_close_ok,
   // Breaker contacts, commands and phase currents in kA.
   input wire logic i_aux_closed,
   input wire logic i_aux_open,
   input wire logic [15:0] i_cur_l1,
   input wire logic [15:0] i_cur_l2,
   input wire logic [15:0] i_cur_l3,
   output logic o_cmd_open,
   output logic o_cmd_close,
   // Position and alarms.
   output swcs_pkg::swcs_pos_t o_pos,
   output logic o_busy,
   output logic o_override_active,
   output logic o_bypass_active,
   output logic o_ops_alarm,
   output logic o_isum_alarm,
   output logic [2:0] o_isum_phase_alarm,
   output logic o_hourly_current_sum_alarm,
   output logic o_maint_due,
   output logic o_wear_curve_alarm,
   output logic o_slow_travel_alarm
);
   import swcs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Complete state of the block.
   typedef struct packed {
      swcs_state_t st;
      swcs_pos_t pos;
      logic dir_close;
      logic cmd_open;
      logic cmd_close;
      logic [31:0] mtmr;
      logic bp_on;
      logic [31:0] bptmr;
      logic kc_q;
      logic ko_q;
      logic ec_q;
      logic [7:0] ctrl;
      logic [31:0] bpdur, opsmax, isumthr, hourthr, topen, tclose;
      logic [3:0] npts;
      logic [6:0] wearlvl;
      logic [N_PTS-1:0][31:0] curve;
      logic [1:0] scada;
      logic [31:0] ops;
      logic [2:0][31:0] sum;
      logic [31:0] wear;
      logic [N_BKT-1:0][31:0] bkt;
      logic [1:0] bidx;
      logic [39:0] bcnt;
      logic slow;
      logic [31:0] prdata;
   } swcs_st_t;

   swcs_st_t r;
   swcs_st_t next_r;

   // Curve size must fit the 4-bit point count; a zero bucket length would never roll.
   if (N_PTS < 2 || N_PTS > 15 || BUCKET_CYCLES == 40'h0) begin : g_chk
      $error("N_PTS must lie between 2 and 15 and BUCKET_CYCLES must not be zero");
   end

   ////////////////////////////////////////////////////////////////////////
   // Position, authority and request decoding.
   swcs_pos_t aux_pos;
   swcs_pos_t cur_pos;
   swcs_auth_t auth;
   swcs_bpmode_t bpmode;
   logic loc_ok, rem_ok, bypass, kc_edge, ko_edge, ec_edge;
   logic rq_open, ok_open, rq_close, ok_close;

   // Contacts give the position; a manual override replaces it.
   always_comb begin
      case ({i_aux_closed, i_aux_open})
         2'b01: aux_pos = POS_OFF;
         2'b10: aux_pos = POS_ON;
         2'b00: aux_pos = POS_INDET;
         default: aux_pos = POS_DIST;
      endcase
      cur_pos = r.ctrl[CTRL_OVR_BIT] ? swcs_pos_t'(r.ctrl[CTRL_OVRPOS_LSB +: 2])
         : aux_pos;
   end

   // Authority and bypass selection.
   assign auth = swcs_auth_t'(r.ctrl[CTRL_AUTH_LSB +: 2]);
   assign bpmode = swcs_bpmode_t'(r.ctrl[CTRL_MODE_LSB +: 2]);
   assign loc_ok = (auth == AUTH_LOCAL) || (auth == AUTH_BOTH);
   assign rem_ok = (auth == AUTH_REMOTE) || (auth == AUTH_BOTH);
   assign bypass = i_bypass_ext || (bpmode == BP_PERM) || r.bp_on;
   assign o_offer_open = loc_ok && (cur_pos != POS_OFF);
   assign o_offer_close = loc_ok && (cur_pos != POS_ON);

   // Edges of the open and close keys and of the external close.
   assign kc_edge = i_key_close && !r.kc_q;
   assign ko_edge = i_key_open && !r.ko_q;
   assign ec_edge = i_ext_close && !r.ec_q;

   // Trip and remote open requests act on level, the open key on its edge; trips ignore authority.
   assign rq_open = i_prot_trip || (o_offer_open && ko_edge)
      || (rem_ok && (i_ext_open || r.scada[0]));
   assign ok_open = rq_open && (cur_pos != POS_OFF)
      && (i_prot_trip || i_ilock_open_ok || bypass);
   assign rq_close = rem_ok && (ec_edge || r.scada[1]);
   assign ok_close = (cur_pos != POS_ON) && (i_ilock_close_ok || bypass);

   ////////////////////////////////////////////////////////////////////////
   // Wear curve evaluation for the largest phase current.
   logic [15:0] imax;
   logic [15:0] allowed;
   logic [N_PTS-2:0] seg_hit;
   logic [N_PTS-2:0][15:0] seg_n;
   logic [31:0] wear_inc;
   logic [32:0] wear_sum;

   assign imax = (i_cur_l1 > i_cur_l2) ? ((i_cur_l1 > i_cur_l3) ? i_cur_l1 : i_cur_l3)
      : ((i_cur_l2 > i_cur_l3) ? i_cur_l2 : i_cur_l3);

   // One interpolation segment between point k and point k+1.
   for (genvar k = 0; k < N_PTS - 1; k++) begin : g_seg
      logic [15:0] c0, c1, n0, n1, dc;
      logic [31:0] prod;
      assign c0 = r.curve[k][15:0];
      assign c1 = r.curve[k+1][15:0];
      assign n0 = (4'(k) == r.npts - 4'h1) ? 16'h0000 : r.curve[k][31:16];
      assign n1 = (4'(k + 1) == r.npts - 4'h1) ? 16'h0000 : r.curve[k+1][31:16];
      assign dc = (c1 > c0) ? (c1 - c0) : 16'h0001;
      assign prod = (n0 - n1) * (imax - c0);
      assign seg_hit[k] = (4'(k + 1) < r.npts) && (imax > c0) && (imax <= c1);
      assign seg_n[k] = n0 - 16'(prod / {16'h0000, dc});
   end

   // Pick the segment; beyond the last used point nothing is allowed.
   always_comb begin
      allowed = 16'h0000;
      if (r.npts == 4'h1) begin
         allowed = 16'h0000;
      end else if (imax <= r.curve[0][15:0]) begin
         allowed = r.curve[0][31:16];
      end
      for (int k = 0; k < N_PTS - 1; k++) begin
         if (seg_hit[k]) begin
            allowed = seg_n[k];
         end
      end
   end

   // Each break consumes one allowed operation's share of capacity.
   assign wear_inc = (allowed == 16'h0000) ? WEAR_FULL : WEAR_FULL / {16'h0000, allowed};
   assign wear_sum = {1'b0, r.wear} + {1'b0, wear_inc};

   ////////////////////////////////////////////////////////////////////////
   // APB decode and status word.
   logic [33:0] hsum;
   logic [6:0] cap_pct;
   logic mapped, in_curve, wr;
   logic [3:0] cidx;
   logic [7:0] coff;
   logic [31:0] rdata;

   assign hsum = {2'b00, r.bkt[0]} + {2'b00, r.bkt[1]} + {2'b00, r.bkt[2]}
      + {2'b00, r.bkt[3]};
   assign cap_pct = r.wear[22:16];
   assign coff = i_paddr - A_CURVE;
   assign cidx = coff[5:2];
   assign in_curve = (i_paddr >= A_CURVE) && (coff[7:2] < 6'(N_PTS));
   assign wr = i_psel && i_penable && i_pwrite;

   // Read multiplexer and map check.
   always_comb begin
      mapped = 1'b1;
      rdata = 32'h0000_0000;
      case (i_paddr)
         A_CTRL: rdata = {24'h000000, r.ctrl};
         A_BPDUR: rdata = r.bpdur;
         A_OPSMAX: rdata = r.opsmax;
         A_ISUMTHR: rdata = r.isumthr;
         A_HOURTHR: rdata = r.hourthr;
         A_TOPEN: rdata = r.topen;
         A_TCLOSE: rdata = r.tclose;
         A_STATUS: rdata = {18'h00000, o_slow_travel_alarm, o_wear_curve_alarm,
            o_maint_due, o_hourly_current_sum_alarm, o_isum_phase_alarm,
            o_isum_alarm, o_ops_alarm, o_bypass_active, o_override_active,
            o_busy, o_pos};
         A_OPS: rdata = r.ops;
         A_SUM1: rdata = r.sum[0];
         A_SUM2: rdata = r.sum[1];
         A_SUM3: rdata = r.sum[2];
         A_CAP: rdata = {25'h0000000, cap_pct};
         A_CMD, A_CLR: rdata = 32'h0000_0000;
         A_NPTS: rdata = {28'h0000000, r.npts};
         A_WEARLVL: rdata = {25'h0000000, r.wearlvl};
         default: begin
            mapped = in_curve;
            rdata = in_curve ? r.curve[cidx] : 32'h0000_0000;
         end
      endcase
      if (i_paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end
   end

   // The slave never waits; unmapped access ends with an error.
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !mapped;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   logic iss_open, iss_close;

   always_comb begin
      next_r = r;
      iss_open = 1'b0;
      iss_close = 1'b0;
      next_r.kc_q = i_key_close;
      next_r.ko_q = i_key_open;
      next_r.ec_q = i_ext_close;
      next_r.scada = 2'b00;
      if (i_psel && !i_penable && !i_pwrite) begin
         next_r.prdata = rdata;
      end
      // Timed and single bypass run down the configured duration.
      if (r.bp_on) begin
         if (r.bptmr == 32'h0000_0000) begin
            next_r.bp_on = 1'b0;
         end else begin
            next_r.bptmr = r.bptmr - 32'h0000_0001;
         end
      end
      // Register writes; the clear of the slow flag yields to a new event.
      if (wr && mapped) begin
         case (i_paddr)
            A_CTRL: begin
               next_r.ctrl = i_pwdata[7:0];
               next_r.bp_on = (i_pwdata[3:2] == BP_SINGLE)
                  || (i_pwdata[3:2] == BP_TIMED);
               next_r.bptmr = r.bpdur;
            end
            A_BPDUR: next_r.bpdur = i_pwdata;
            A_OPSMAX: next_r.opsmax = i_pwdata;
            A_ISUMTHR: next_r.isumthr = i_pwdata;
            A_HOURTHR: next_r.hourthr = i_pwdata;
            A_TOPEN: next_r.topen = i_pwdata;
            A_TCLOSE: next_r.tclose = i_pwdata;
            A_CMD: next_r.scada = i_pwdata[1:0];
            A_CLR: next_r.slow = r.slow && !i_pwdata[0];
            A_NPTS: next_r.npts = (i_pwdata[3:0] == 4'h0) ? 4'h1
               : ((i_pwdata[3:0] > 4'(N_PTS)) ? 4'(N_PTS) : i_pwdata[3:0]);
            A_WEARLVL: next_r.wearlvl = i_pwdata[6:0];
            default: begin
               if (in_curve) begin
                  next_r.curve[cidx] = i_pwdata;
               end
            end
         endcase
      end
      // Quarter-hour buckets roll so the sum covers the last hour.
      if (r.bcnt >= BUCKET_CYCLES - 40'h1) begin
         next_r.bcnt = 40'h0;
         next_r.bidx = r.bidx + 2'b01;
         next_r.bkt[r.bidx + 2'b01] = 32'h0000_0000;
      end else begin
         next_r.bcnt = r.bcnt + 40'h1;
      end
      // Command sequencer; new requests are seen while idle, and a trip is also seen while confirming.
      case (r.st)
         ST_IDLE: begin
            next_r.pos = cur_pos;
            if (ok_open) begin
               iss_open = 1'b1;
            end else if (o_offer_close && kc_edge) begin
               next_r.st = ST_CONFIRM;
            end else if (rq_close && ok_close) begin
               iss_close = 1'b1;
            end
         end
         ST_CONFIRM: begin
            next_r.pos = cur_pos;
            if (i_prot_trip && ok_open) begin
               iss_open = 1'b1;
            end else if (i_key_no || !o_offer_close) begin
               next_r.st = ST_IDLE;
            end else if (i_key_yes) begin
               iss_close = ok_close;
               next_r.st = ST_IDLE;
            end
         end
         ST_MOVE: begin
            next_r.mtmr = r.mtmr - 32'h0000_0001;
            if (cur_pos == (r.dir_close ? POS_ON : POS_OFF)) begin
               next_r.pos = cur_pos;
               next_r.st = ST_IDLE;
               next_r.cmd_open = 1'b0;
               next_r.cmd_close = 1'b0;
            end else if (r.mtmr == 32'h0000_0000) begin
               next_r.pos = cur_pos;
               next_r.slow = 1'b1;
               next_r.st = ST_IDLE;
               next_r.cmd_open = 1'b0;
               next_r.cmd_close = 1'b0;
            end
         end
         default: next_r.st = ST_IDLE;
      endcase
      // Issue one command and book it in the statistics.
      if (iss_open || iss_close) begin
         next_r.st = ST_MOVE;
         next_r.cmd_open = iss_open;
         next_r.cmd_close = iss_close;
         next_r.dir_close = iss_close;
         next_r.mtmr = iss_close ? r.tclose : r.topen;
         next_r.ops = r.ops + 32'h0000_0001;
         if (bpmode == BP_SINGLE && !i_prot_trip) begin
            next_r.bp_on = 1'b0;
         end
      end
      if (iss_open) begin
         next_r.sum[0] = r.sum[0] + {16'h0000, i_cur_l1};
         next_r.sum[1] = r.sum[1] + {16'h0000, i_cur_l2};
         next_r.sum[2] = r.sum[2] + {16'h0000, i_cur_l3};
         next_r.bkt[r.bidx] = r.bkt[r.bidx] + {16'h0000, imax};
         next_r.wear = (wear_sum > {1'b0, WEAR_FULL}) ? WEAR_FULL
            : wear_sum[31:0];
      end
      // Synchronous reset clears everything and loads settings.
      if (!i_rst_n) begin
         next_r = '0;
         next_r.ctrl = CTRL_RST;
         next_r.bpdur = BPDUR_RST;
         next_r.opsmax = LIMIT_RST;
         next_r.isumthr = LIMIT_RST;
         next_r.hourthr = LIMIT_RST;
         next_r.topen = TMOVE_RST;
         next_r.tclose = TMOVE_RST;
         next_r.npts = NPTS_RST;
         next_r.wearlvl = WEARLVL_RST;
      end
   end

   // State register.
   always_ff @(posedge i_clk_sys) begin
      r <= next_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign o_prdata = r.prdata;
   assign o_cmd_open = r.cmd_open;
   assign o_cmd_close = r.cmd_close;
   assign o_pos = r.pos;
   assign o_busy = (r.st != ST_IDLE);
   assign o_confirm_pending = (r.st == ST_CONFIRM);
   assign o_override_active = r.ctrl[CTRL_OVR_BIT];
   assign o_bypass_active = bypass;
   assign o_ops_alarm = (r.ops > r.opsmax);
   for (genvar p = 0; p < 3; p++) begin : g_ph
      assign o_isum_phase_alarm[p] = (r.sum[p] > r.isumthr);
   end
   assign o_isum_alarm = |o_isum_phase_alarm;
   assign o_hourly_current_sum_alarm = (hsum > {2'b00, r.hourthr});
   assign o_maint_due = (cap_pct >= CAP_FULL);
   assign o_wear_curve_alarm = (cap_pct >= r.wearlvl);
   assign o_slow_travel_alarm = r.slow;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   cmd_excl_a: assert property (!(o_cmd_open && o_cmd_close))
      else $error("open and close commands together");
   dir_check_a: assert property ($rose(o_cmd_open) |-> $past(cur_pos) != POS_OFF)
      else $error("open issued on an open switchgear");
   one_cmd_a: assert property (o_busy && $past(o_busy) && $past(r.st) == ST_MOVE
      |-> $stable(r.ops))
      else $error("operation counted while a command runs");
   confirm_yes_a: assert property ($rose(o_cmd_close) && $past(r.st) == ST_CONFIRM
      |-> $past(i_key_yes))
      else $error("close without confirmation");
   key_edge_a: assert property ($rose(o_confirm_pending)
      |-> $past(i_key_close) && !$past(r.kc_q) && $past(loc_ok))
      else $error("confirmation without key edge");
   auth_none_a: assert property ($past(auth) == AUTH_NONE && !$past(i_prot_trip)
      && $past(r.st) != ST_MOVE |-> !$rose(o_cmd_open) && !$rose(o_cmd_close))
      else $error("command issued with no authority");
   override_a: assert property (r.ctrl[CTRL_OVR_BIT] && r.st == ST_IDLE
      |=> o_pos == $past(swcs_pos_t'(r.ctrl[CTRL_OVRPOS_LSB +: 2])))
      else $error("override position not shown");
   maint_a: assert property (o_maint_due |-> r.wear == WEAR_FULL)
      else $error("maintenance without full capacity");
   slow_a: assert property ($rose(o_slow_travel_alarm)
      |-> $past(r.st) == ST_MOVE && $past(r.mtmr) == 32'h0000_0000)
      else $error("slow flag without timeout");
   ops_cnt_a: assert property ($rose(o_busy) && !o_confirm_pending
      |-> r.ops == $past(r.ops) + 32'h0000_0001)
      else $error("operation not counted");
   bp_end_a: assert property (r.bp_on && r.bptmr == 32'h0000_0000 && !(wr && mapped)
      |=> !r.bp_on)
      else $error("bypass outlived its duration");
endmodule

// File: dv/swcs_breaker.sv
`timescale 1ns/1ps
// Breaker that travels for a few cycles and can be held stuck.
module swcs_breaker #(
   parameter int DLY = 3
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_cmd_open,
   input wire logic i_cmd_close,
   input wire logic i_stall,
   output logic o_aux_closed,
   output logic o_aux_open
);
   logic closed;
   int cnt;
   // Both contacts drop while the poles travel.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         closed <= 1'b1;
         cnt <= 0;
      end else if ((i_cmd_open && closed || i_cmd_close && !closed) && !i_stall) begin
         cnt <= (cnt == DLY) ? 0 : cnt + 1;
         if (cnt == DLY) begin
            closed <= !closed;
         end
      end else begin
         cnt <= 0;
      end
   end
   // Contacts show the end position only at rest.
   assign o_aux_closed = closed && cnt == 0;
   assign o_aux_open = !closed && cnt == 0;
endmodule

// File: dv/test_swcs_supervisor.sv
`timescale 1ns/1ps
module test_swcs_supervisor;
   import swcs_pkg::*;
   logic i_clk_sys = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic [7:0] i_paddr = 0;
   logic [31:0] i_pwdata = 0, o_prdata, rd;
   logic o_pready, o_pslverr, serr, o_offer_open, o_offer_close, o_confirm_pending;
   logic i_key_open = 0, i_key_close = 0, i_key_yes = 0, i_key_no = 0;
   logic i_ext_open = 0, i_ext_close = 0, i_prot_trip = 0, i_bypass_ext = 0;
   logic i_ilock_open_ok = 1, i_ilock_close_ok = 1, i_aux_closed, i_aux_open, stall = 0;
   logic [15:0] i_cur_l1 = 16'h0003, i_cur_l2 = 16'h0001, i_cur_l3 = 16'h0002;
   logic o_cmd_open, o_cmd_close, o_busy, o_override_active, o_bypass_active;
   logic o_ops_alarm, o_isum_alarm, o_hourly_current_sum_alarm, o_maint_due;
   logic o_wear_curve_alarm, o_slow_travel_alarm;
   logic [2:0] o_isum_phase_alarm;
   swcs_pos_t o_pos;
   int errors = 0, check_count = 0, hi;
   logic [39:0] rows [8] = '{{A_CTRL, 24'h0, CTRL_RST}, {A_BPDUR, BPDUR_RST},
      {A_TOPEN, TMOVE_RST}, {A_TCLOSE, TMOVE_RST}, {A_OPSMAX, LIMIT_RST},
      {A_NPTS, 28'h0, NPTS_RST}, {A_WEARLVL, 25'h0, WEARLVL_RST}, {A_OPS, 32'h0}};
   swcs_supervisor #(.N_PTS(10), .BUCKET_CYCLES(40'h64)) dut (.i_clk_sys, .i_rst_n,
      .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
      .o_pslverr, .i_key_open, .i_key_close, .i_key_yes, .i_key_no, .o_offer_open,
      .o_offer_close, .o_confirm_pending, .i_ext_open, .i_ext_close, .i_prot_trip,
      .i_bypass_ext, .i_ilock_open_ok, .i_ilock_close_ok, .i_aux_closed, .i_aux_open,
      .i_cur_l1, .i_cur_l2, .i_cur_l3, .o_cmd_open, .o_cmd_close, .o_pos, .o_busy,
      .o_override_active, .o_bypass_active, .o_ops_alarm, .o_isum_alarm,
      .o_isum_phase_alarm, .o_hourly_current_sum_alarm, .o_maint_due,
      .o_wear_curve_alarm, .o_slow_travel_alarm);
   swcs_breaker #(.DLY(3)) brk (.i_clk_sys, .i_rst_n, .i_cmd_open(o_cmd_open),
      .i_cmd_close(o_cmd_close), .i_stall(stall), .o_aux_closed(i_aux_closed),
      .o_aux_open(i_aux_open));
   // Clock at 40 MHz.
   always #12.5 i_clk_sys = ~i_clk_sys;
   // Prints the counts and the verdict, then stops.
   task wrap_up();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Compares one value and counts it.
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected %0s: expected %h seen %h", s, e, g);
      end
   endtask
   // One APB transfer, held until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk_sys);
      {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
      @(posedge i_clk_sys) i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         wrap_up();
      end
      rd = o_prdata;
      serr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // Waits for a command and counts the cycles it stands.
   task run();
      int n;
      n = 0;
      hi = 0;
      while (!(o_cmd_open | o_cmd_close) && n < 20) begin
         @(posedge i_clk_sys);
         n++;
      end
      while ((o_cmd_open | o_cmd_close) === 1'b1 && hi < 100) begin
         @(posedge i_clk_sys);
         hi++;
      end
      if (n >= 20 || hi >= 100) begin
         errors++;
         wrap_up();
      end
      @(posedge i_clk_sys);
   endtask
   // Pulses one external request for a single cycle.
   task ext(input logic op);
      @(posedge i_clk_sys) {i_ext_open, i_ext_close} <= {op, !op};
      @(posedge i_clk_sys) {i_ext_open, i_ext_close} <= 2'b00;
   endtask
   // Main sequence.
   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      foreach (rows[k]) begin
         apb(0, rows[k][39:32], 0);
         chk("reset reg", rows[k][31:0], rd);
      end
      apb(0, 8'h7C, 0);
      chk("unmapped error", 1, serr);
      chk("unmapped data", 0, rd);
      // External bypass, then a single bypass that runs out unused.
      i_bypass_ext <= 1'b1;
      @(posedge i_clk_sys);
      chk("ext bypass", 1, o_bypass_active);
      i_bypass_ext <= 1'b0;
      apb(1, A_BPDUR, 5);
      apb(1, A_CTRL, 32'h07);
      @(posedge i_clk_sys);
      chk("single bypass", 1, o_bypass_active);
      repeat (8) @(posedge i_clk_sys);
      chk("bypass expiry", 0, o_bypass_active);
      // Override shows open although the contacts say closed.
      apb(1, A_CTRL, 32'h33);
      repeat (2) @(posedge i_clk_sys);
      chk("override", {1'b1, POS_OFF}, {o_override_active, o_pos});
      apb(1, A_CTRL, CTRL_RST);
      $display("test reset done");
      apb(1, A_TOPEN, 8);
      apb(1, A_TCLOSE, 8);
      apb(1, A_OPSMAX, 1);
      apb(1, A_ISUMTHR, 2);
      apb(1, A_HOURTHR, 2);
      ext(1);
      run();
      chk("open pos", POS_OFF, o_pos);
      apb(0, A_SUM1, 0);
      chk("sum l1", 3, rd);
      // The reset curve allows nothing above its last point, so one break uses it all.
      apb(0, A_CAP, 0);
      chk("capacity", CAP_FULL, rd);
      chk("maint wear", 2'b11, {o_maint_due, o_wear_curve_alarm});
      chk("phase alarms", 4'b1001, {o_isum_alarm, o_isum_phase_alarm});
      chk("hour alarm", 1, o_hourly_current_sum_alarm);
      ext(1);
      repeat (4) @(posedge i_clk_sys);
      chk("repeat open", 0, {o_busy, o_cmd_open});
      ext(0);
      run();
      apb(0, A_OPS, 0);
      chk("ops", 2, rd);
      chk("ops alarm", 1, o_ops_alarm);
      $display("test open close done");
      stall <= 1'b1;
      ext(1);
      run();
      chk("slow hold", 9, hi);
      chk("slow flag", 1, o_slow_travel_alarm);
      chk("slow pos", POS_ON, o_pos);
      apb(1, A_CLR, 1);
      @(posedge i_clk_sys);
      chk("slow clear", 0, o_slow_travel_alarm);
      stall <= 1'b0;
      ext(1);
      run();
      chk("offers", 2'b01, {o_offer_open, o_offer_close});
      // First close sticks, so the held key stays offered and must not act again.
      stall <= 1'b1;
      for (int t = 0; t < 2; t++) begin
         i_key_close <= 1'b1;
         repeat (3) @(posedge i_clk_sys);
         chk("confirm", 2'b10, {o_confirm_pending, o_cmd_close});
         i_key_yes <= 1'b1;
         @(posedge i_clk_sys) i_key_yes <= 1'b0;
         run();
         repeat (10) @(posedge i_clk_sys);
         chk("one pulse", 0, {o_busy, o_confirm_pending, o_cmd_close});
         chk("close pos", t ? POS_ON : POS_OFF, o_pos);
         stall <= 1'b0;
         i_key_close <= 1'b0;
         @(posedge i_clk_sys);
      end
      $display("test local close done");
      // Four bucket lengths after the last break the hourly sum is empty again.
      repeat (420) @(posedge i_clk_sys);
      chk("hour roll", 0, o_hourly_current_sum_alarm);
      i_rst_n <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      apb(0, A_OPS, 0);
      chk("ops after reset", 0, rd);
      chk("flags after reset", 0, {o_slow_travel_alarm, o_maint_due, o_ops_alarm});
      $display("test reset again done");
      wrap_up();
   end
endmodule
